// [dsl_slice_defines.svh]
// Constants of the arithmetic slice wrapper: widths, control word fields, limits.
// Assumes it is included by its bare name from the package and the modules.
`ifndef DSL_SLICE_DEFINES_SVH
`define DSL_SLICE_DEFINES_SVH

// ----------------------------------------------------------------
// Data widths
// ----------------------------------------------------------------
`define DSL_AW 30
`define DSL_BW 18
`define DSL_CW 48
`define DSL_DW 25
`define DSL_MW 43
`define DSL_PW 48
`define DSL_SEGW 12
`define DSL_NSEG 4

// ----------------------------------------------------------------
// Consolidated control word
// ----------------------------------------------------------------
`define DSL_CTRLW 20
`define DSL_OPSEL_LSB 0
`define DSL_OPSEL_W 7
`define DSL_ALUFN_LSB 7
`define DSL_ALUFN_W 4
`define DSL_CIN_BIT 11
`define DSL_CSEL_LSB 12
`define DSL_CSEL_W 3
`define DSL_INMODE_LSB 15
`define DSL_INMODE_W 5

// ----------------------------------------------------------------
// Detector limits and reset values
// ----------------------------------------------------------------
`define DSL_N_MIN 1
`define DSL_N_MAX 46
`define DSL_PATTERN_RST 48'h0
`define DSL_MASK_RST 48'hFFFF_FFFF_FF00
`define DSL_SHIFT 17

`endif

// [dsl_pkg.sv]
// Types shared by the arithmetic slice wrapper modules.
// Assumes dsl_slice_defines.svh is on the include path.
package dsl_pkg;
    `include "dsl_slice_defines.svh"

    typedef enum logic [1:0] {
        DSL_SIMD_ONE = 2'b00,
        DSL_SIMD_TWO = 2'b01,
        DSL_SIMD_FOUR = 2'b10
    } dsl_simd_e;

    typedef enum logic [3:0] {
        DSL_FN_ADD = 4'b0000,
        DSL_FN_NEGZ = 4'b0001,
        DSL_FN_NOTADD = 4'b0010,
        DSL_FN_SUBZ = 4'b0011,
        DSL_FN_XOR = 4'b0100,
        DSL_FN_AND = 4'b1100,
        DSL_FN_OR = 4'b1110
    } dsl_alu_e;

    typedef logic [`DSL_PW-1:0] dsl_word_t;
endpackage

// [dsl_alu_if.sv]
// Bundle between the slice top and its adder/logic unit.
// Assumes dsl_pkg is compiled first.
`timescale 1ns/10ps
interface dsl_alu_if;
    dsl_pkg::dsl_word_t x;
    dsl_pkg::dsl_word_t y;
    dsl_pkg::dsl_word_t z;
    logic cin;
    logic [3:0] fn;
    dsl_pkg::dsl_simd_e simd;
    dsl_pkg::dsl_word_t res;
    logic [3:0] cout;
    logic cascOut;

    modport core (input x, y, z, cin, fn, simd, output res, cout, cascOut);
    modport user (output x, y, z, cin, fn, simd, input res, cout, cascOut);
endinterface

// [dsl_stage.sv]
// One optional register stage with synchronous reset and enable.
// Assumes a single clock; when PRESENT is 0 the stage is a plain wire.
`timescale 1ns/10ps
module dsl_stage #(
    parameter int W = 1,
    parameter bit PRESENT = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Stage control
    input wire logic srst,
    input wire logic ce,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    generate
        if (PRESENT) begin : g_reg
            logic [W-1:0] q_r;
            logic [W-1:0] q_nxt;
            always_comb begin
                q_nxt = q_r;
                if (srst) begin
                    q_nxt = '0;
                end else if (ce) begin
                    q_nxt = d;
                end
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    q_r <= '0;
                end else if (clkEn) begin
                    q_r <= q_nxt;
                end
            end
            assign q = q_r;
        end else begin : g_wire
            assign q = d;
        end
    endgenerate
endmodule

// [dsl_alu.sv]
// SIMD adder/subtracter/logic unit of the slice.
// Assumes the caller keeps Y at zero in split modes, as the multiplier is idle then.
`timescale 1ns/10ps
`include "dsl_slice_defines.svh"
module dsl_alu (
    // Operands and results
    dsl_alu_if.core bus
);
    logic [`DSL_PW-1:0] xy;
    logic [`DSL_PW-1:0] zz;
    logic [`DSL_PW-1:0] sum;
    logic [`DSL_NSEG:0] ch;
    logic subZ;

    assign subZ = (bus.fn == dsl_pkg::DSL_FN_SUBZ) || (bus.fn == dsl_pkg::DSL_FN_NEGZ);
    assign xy = bus.x + bus.y;
    assign zz = subZ ? ~bus.z : bus.z;
    assign ch[0] = bus.cin;

    // ----------------------------------------------------------------
    // Segments: a unit starts where the SIMD split puts a boundary
    // ----------------------------------------------------------------
    generate
        for (genvar k = 0; k < `DSL_NSEG; k++) begin : g_seg
            logic start;
            logic segIn;
            assign start = (k == 0) || (bus.simd == dsl_pkg::DSL_SIMD_FOUR) ||
                           ((bus.simd == dsl_pkg::DSL_SIMD_TWO) && (k == 2));
            assign segIn = start ? bus.cin : ch[k];
            assign {ch[k+1], sum[k*`DSL_SEGW +: `DSL_SEGW]} =
                {1'b0, zz[k*`DSL_SEGW +: `DSL_SEGW]} +
                {1'b0, xy[k*`DSL_SEGW +: `DSL_SEGW]} + {12'h000, segIn};
        end
    endgenerate

    always_comb begin
        case (bus.fn)
            dsl_pkg::DSL_FN_ADD: bus.res = sum;
            dsl_pkg::DSL_FN_NEGZ: bus.res = sum;
            dsl_pkg::DSL_FN_SUBZ: bus.res = ~sum;
            dsl_pkg::DSL_FN_NOTADD: bus.res = ~sum;
            dsl_pkg::DSL_FN_XOR: bus.res = bus.x ^ bus.z;
            dsl_pkg::DSL_FN_AND: bus.res = bus.x & bus.z;
            dsl_pkg::DSL_FN_OR: bus.res = bus.x | bus.z;
            default: bus.res = sum;
        endcase
    end

    // Lowest unit in bit 0, highest unit in the top used bit
    always_comb begin
        case (bus.simd)
            dsl_pkg::DSL_SIMD_ONE: bus.cout = {3'h0, ch[4]};
            dsl_pkg::DSL_SIMD_TWO: bus.cout = {2'h0, ch[4], ch[2]};
            dsl_pkg::DSL_SIMD_FOUR: bus.cout = ch[4:1];
            default: bus.cout = {3'h0, ch[4]};
        endcase
    end

    assign bus.cascOut = ch[4];
endmodule

// [dsl_slice.sv]
// Top of the arithmetic slice wrapper: optional ports, pipeline stages,
// pre-adder, multiplier, SIMD adder and pattern, overflow and underflow flags.
// Assumes one clock; cascade ports join only adjacent slices of the same kind.
// What this block does
// - Consolidated 20-bit control word split into fields
// - Hidden third operand reads as zero
// - Global reset drives every present stage reset
// - Global enable drives every present stage enable
// - Carry output width follows the SIMD split
// - Pattern flag set on masked pattern equality
// - Inverse flag set on masked inverted equality
// - Overflow flags result beyond bit N
// - Underflow flags result below minus bit N
// - Sign cascade joins next slice for wide accumulators
// - Operand input pipelines configurable, zero bypasses
// - Cascade-out depth not above input depth
// - Each listed path has selectable register stage
// - Separate active-high resets clear their registers
// - Control reset clears operation and carry select
// - Separate enables for both operand pipeline stages
// - Control enable gates operation and carry select
// - Optional enables for pre-adder and input mode
// - Adder splits into one, two or four units
// - Pre-adder adds data input to first operand
// - Auto reset clears output after a match
`timescale 1ns/10ps
`include "dsl_slice_defines.svh"
module dsl_slice #(
    parameter bit CONSOLIDATE = 1'b1,
    parameter bit USE_C = 1'b1,
    parameter bit USE_GLOBAL_RST = 1'b0,
    parameter bit USE_GLOBAL_EN = 1'b0,
    parameter bit USE_SEP_RST = 1'b1,
    parameter bit USE_SEP_CE = 1'b1,
    parameter bit A_FROM_CASC = 1'b0,
    parameter bit B_FROM_CASC = 1'b0,
    parameter int AREG = 1,
    parameter int BREG = 1,
    parameter int ACASCREG = 1,
    parameter int BCASCREG = 1,
    parameter bit CREG = 1'b1,
    parameter bit PREG = 1'b1,
    parameter bit MREG = 1'b1,
    parameter bit OPREG = 1'b1,
    parameter bit ALUREG = 1'b1,
    parameter bit CINREG = 1'b1,
    parameter bit CSELREG = 1'b1,
    parameter bit DREG = 1'b1,
    parameter bit ADREG = 1'b1,
    parameter bit INREG = 1'b1,
    parameter bit USE_PREADD = 1'b0,
    parameter dsl_pkg::dsl_simd_e SIMD = dsl_pkg::DSL_SIMD_ONE,
    parameter bit PAT_FROM_C = 1'b0,
    parameter bit MASK_FROM_C = 1'b0,
    parameter logic [`DSL_PW-1:0] PATTERN = `DSL_PATTERN_RST,
    parameter logic [`DSL_PW-1:0] MASK = `DSL_MASK_RST,
    parameter bit AUTORESET = 1'b0
) (
    // Clock, reset, freeze
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Data operands
    input wire logic [`DSL_AW-1:0] a,
    input wire logic [`DSL_BW-1:0] b,
    input wire logic [`DSL_CW-1:0] c,
    input wire logic [`DSL_DW-1:0] d,
    // Control, consolidated or separate
    input wire logic [`DSL_CTRLW-1:0] ctrlWord,
    input wire logic [`DSL_OPSEL_W-1:0] opSel,
    input wire logic [`DSL_ALUFN_W-1:0] aluFn,
    input wire logic carryIn,
    input wire logic [`DSL_CSEL_W-1:0] carrySel,
    input wire logic [`DSL_INMODE_W-1:0] inMode,
    // Global reset and enable
    input wire logic globalRst,
    input wire logic globalEn,
    // Separate resets, active high
    input wire logic firstOperandRst,
    input wire logic secondOperandRst,
    input wire logic thirdOperandRst,
    input wire logic multRst,
    input wire logic outputRst,
    input wire logic carryInRst,
    input wire logic aluFnRst,
    input wire logic ctrlRst,
    input wire logic preAddRst,
    input wire logic inModeRst,
    // Separate enables
    input wire logic firstOperandStage1Enable,
    input wire logic firstOperandStage2Enable,
    input wire logic secondOperandStage1Enable,
    input wire logic secondOperandStage2Enable,
    input wire logic thirdOperandEnable,
    input wire logic multEnable,
    input wire logic outputEnable,
    input wire logic carryInEnable,
    input wire logic aluFnEnable,
    input wire logic ctrlEnable,
    input wire logic preAddInEnable,
    input wire logic preAddOutEnable,
    input wire logic inModeEnable,
    // Cascade inputs
    input wire logic [`DSL_AW-1:0] aCascIn,
    input wire logic [`DSL_BW-1:0] bCascIn,
    input wire logic [`DSL_PW-1:0] pCascIn,
    input wire logic carryCascIn,
    input wire logic multSignCascIn,
    // Results
    output logic [`DSL_PW-1:0] p,
    output logic [3:0] carryOut,
    output logic patternMatch,
    output logic patternInvMatch,
    output logic overflow,
    output logic underflow,
    // Cascade outputs
    output logic [`DSL_AW-1:0] aCascOut,
    output logic [`DSL_BW-1:0] bCascOut,
    output logic [`DSL_PW-1:0] pCascOut,
    output logic carryCascOut,
    output logic multSignCascOut
);
    localparam int FW = `DSL_PW + 8;

    // ----------------------------------------------------------------
    // Reset and enable steering
    // ----------------------------------------------------------------
    logic gRst;
    logic gEn;
    assign gRst = USE_GLOBAL_RST ? globalRst : 1'b0;
    assign gEn = USE_GLOBAL_EN ? globalEn : 1'b1;

    function automatic logic rstOf(input logic own, input logic g);
        return g | (USE_SEP_RST ? own : 1'b0);
    endfunction
    function automatic logic ceOf(input logic own, input logic g);
        return g & (USE_SEP_CE ? own : 1'b1);
    endfunction

    // ----------------------------------------------------------------
    // Control sources
    // ----------------------------------------------------------------
    logic [`DSL_OPSEL_W-1:0] opSrc;
    logic [`DSL_ALUFN_W-1:0] fnSrc;
    logic cinSrc;
    logic [`DSL_CSEL_W-1:0] cselSrc;
    logic [`DSL_INMODE_W-1:0] inSrc;
    always_comb begin
        if (CONSOLIDATE) begin
            opSrc = ctrlWord[`DSL_OPSEL_LSB +: `DSL_OPSEL_W];
            fnSrc = ctrlWord[`DSL_ALUFN_LSB +: `DSL_ALUFN_W];
            cinSrc = ctrlWord[`DSL_CIN_BIT];
            cselSrc = ctrlWord[`DSL_CSEL_LSB +: `DSL_CSEL_W];
            inSrc = ctrlWord[`DSL_INMODE_LSB +: `DSL_INMODE_W];
        end else begin
            opSrc = opSel;
            fnSrc = aluFn;
            cinSrc = carryIn;
            cselSrc = carrySel;
            inSrc = inMode;
        end
    end

    logic [`DSL_OPSEL_W-1:0] opQ;
    logic [`DSL_ALUFN_W-1:0] fnQ;
    logic cinQ;
    logic [`DSL_CSEL_W-1:0] cselQ;
    logic [`DSL_INMODE_W-1:0] inQ;
    // Operation select and carry select share one reset and one enable
    dsl_stage #(.W(`DSL_OPSEL_W), .PRESENT(OPREG)) uOp (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(ctrlRst, gRst)), .ce(ceOf(ctrlEnable, gEn)),
        .d(opSrc), .q(opQ));
    dsl_stage #(.W(`DSL_CSEL_W), .PRESENT(CSELREG)) uCsel (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(ctrlRst, gRst)), .ce(ceOf(ctrlEnable, gEn)),
        .d(cselSrc), .q(cselQ));
    dsl_stage #(.W(`DSL_ALUFN_W), .PRESENT(ALUREG)) uFn (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(aluFnRst, gRst)), .ce(ceOf(aluFnEnable, gEn)),
        .d(fnSrc), .q(fnQ));
    dsl_stage #(.W(1), .PRESENT(CINREG)) uCin (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(carryInRst, gRst)), .ce(ceOf(carryInEnable, gEn)),
        .d(cinSrc), .q(cinQ));
    dsl_stage #(.W(`DSL_INMODE_W), .PRESENT(INREG)) uIn (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(inModeRst, gRst)), .ce(ceOf(inModeEnable, gEn)),
        .d(inSrc), .q(inQ));

    // ----------------------------------------------------------------
    // Operand pipelines
    // ----------------------------------------------------------------
    logic [`DSL_AW-1:0] aSrc;
    logic [`DSL_AW-1:0] a1Q;
    logic [`DSL_AW-1:0] aQ;
    logic [`DSL_BW-1:0] bSrc;
    logic [`DSL_BW-1:0] b1Q;
    logic [`DSL_BW-1:0] bQ;
    assign aSrc = A_FROM_CASC ? aCascIn : a;
    assign bSrc = B_FROM_CASC ? bCascIn : b;

    // A single stage sits in the second position and uses the second enable
    dsl_stage #(.W(`DSL_AW), .PRESENT(AREG == 2)) uA1 (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(firstOperandRst, gRst)),
        .ce(ceOf(firstOperandStage1Enable, gEn)), .d(aSrc), .q(a1Q));
    dsl_stage #(.W(`DSL_AW), .PRESENT(AREG >= 1)) uA2 (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(firstOperandRst, gRst)),
        .ce(ceOf(firstOperandStage2Enable, gEn)), .d(a1Q), .q(aQ));
    dsl_stage #(.W(`DSL_BW), .PRESENT(BREG == 2)) uB1 (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(secondOperandRst, gRst)),
        .ce(ceOf(secondOperandStage1Enable, gEn)), .d(bSrc), .q(b1Q));
    dsl_stage #(.W(`DSL_BW), .PRESENT(BREG >= 1)) uB2 (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(secondOperandRst, gRst)),
        .ce(ceOf(secondOperandStage2Enable, gEn)), .d(b1Q), .q(bQ));

    // Cascade taps; a depth above the input depth is clamped to it
    assign aCascOut = (ACASCREG == 0) ? aSrc :
                      ((ACASCREG >= AREG) ? aQ : a1Q);
    assign bCascOut = (BCASCREG == 0) ? bSrc :
                      ((BCASCREG >= BREG) ? bQ : b1Q);

    // ----------------------------------------------------------------
    // Third operand and pre-adder
    // ----------------------------------------------------------------
    logic [`DSL_CW-1:0] cSrc;
    logic [`DSL_CW-1:0] cQ;
    assign cSrc = USE_C ? c : '0;
    dsl_stage #(.W(`DSL_CW), .PRESENT(CREG)) uC (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(thirdOperandRst, gRst)),
        .ce(ceOf(thirdOperandEnable, gEn)), .d(cSrc), .q(cQ));

    logic [`DSL_DW-1:0] dQ;
    logic [`DSL_DW-1:0] adSum;
    logic [`DSL_DW-1:0] adQ;
    logic [`DSL_DW-1:0] aPre;
    dsl_stage #(.W(`DSL_DW), .PRESENT(DREG)) uD (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(preAddRst, gRst)),
        .ce(ceOf(preAddInEnable, gEn)), .d(d), .q(dQ));

    // Mode bit 1 blanks the first operand, bit 2 adds the data input, bit 3 subtracts
    always_comb begin
        aPre = inQ[1] ? '0 : aQ[`DSL_DW-1:0];
        if (!inQ[2]) begin
            adSum = aPre;
        end else if (inQ[3]) begin
            adSum = dQ - aPre;
        end else begin
            adSum = dQ + aPre;
        end
    end
    dsl_stage #(.W(`DSL_DW), .PRESENT(ADREG)) uAd (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(preAddRst, gRst)),
        .ce(ceOf(preAddOutEnable, gEn)), .d(adSum), .q(adQ));

    // ----------------------------------------------------------------
    // Multiplier
    // ----------------------------------------------------------------
    logic [`DSL_DW-1:0] mulA;
    logic [`DSL_MW-1:0] mProd;
    logic [`DSL_MW-1:0] mQ;
    assign mulA = USE_PREADD ? adQ : aQ[`DSL_DW-1:0];
    assign mProd = `DSL_MW'($signed(mulA) * $signed(bQ));
    dsl_stage #(.W(`DSL_MW), .PRESENT(MREG)) uM (.clk(clk), .rst_n(rst_n),
        .clkEn(clkEn), .srst(rstOf(multRst, gRst)), .ce(ceOf(multEnable, gEn)),
        .d(mProd), .q(mQ));

    // ----------------------------------------------------------------
    // Operand selection into the adder
    // ----------------------------------------------------------------
    dsl_alu_if alu ();
    logic [`DSL_PW-1:0] mExt;
    logic cinSel;
    assign mExt = {{(`DSL_PW-`DSL_MW){mQ[`DSL_MW-1]}}, mQ};

    // Feedback from the output relies on the output stage being present
    always_comb begin
        case (opQ[1:0])
            2'h1: alu.x = mExt;
            2'h2: alu.x = p;
            2'h3: alu.x = {aQ, bQ};
            default: alu.x = '0;
        endcase
        case (opQ[3:2])
            2'h2: alu.y = {`DSL_PW{1'b1}};
            2'h3: alu.y = cQ;
            default: alu.y = '0;
        endcase
        case (opQ[6:4])
            3'h1: alu.z = pCascIn;
            3'h2: alu.z = p;
            3'h3: alu.z = cQ;
            3'h4: alu.z = p;
            3'h5: alu.z = {{`DSL_SHIFT{pCascIn[`DSL_PW-1]}}, pCascIn[`DSL_PW-1:`DSL_SHIFT]};
            3'h6: alu.z = {{`DSL_SHIFT{p[`DSL_PW-1]}}, p[`DSL_PW-1:`DSL_SHIFT]};
            3'h7: alu.z = {{`DSL_SHIFT{multSignCascIn}}, p[`DSL_PW-1:`DSL_SHIFT]};
            default: alu.z = '0;
        endcase
        case (cselQ)
            3'h1: cinSel = ~pCascIn[`DSL_PW-1];
            3'h2: cinSel = carryCascIn;
            3'h3: cinSel = pCascIn[`DSL_PW-1];
            default: cinSel = cinQ;
        endcase
    end
    assign alu.cin = cinSel;
    assign alu.fn = fnQ;
    assign alu.simd = SIMD;

    dsl_alu uAlu (.bus(alu.core));

    // ----------------------------------------------------------------
    // Pattern, overflow and underflow detection
    // ----------------------------------------------------------------
    logic [`DSL_PW-1:0] pat;
    logic [`DSL_PW-1:0] msk;
    logic [`DSL_PW-1:0] thr;
    logic [5:0] ones;
    logic [5:0] nBit;
    logic patHit;
    logic patInvHit;
    logic ovf;
    logic unf;
    assign pat = PAT_FROM_C ? cQ : PATTERN;
    assign msk = MASK_FROM_C ? cQ : MASK;
    assign patHit = &((alu.res ~^ pat) | msk);
    assign patInvHit = &((alu.res ~^ ~pat) | msk);

    always_comb begin
        ones = 6'h00;
        for (int i = 0; i < `DSL_PW; i++) begin
            ones = ones + {5'h00, msk[i]};
        end
        if (ones < 6'(`DSL_N_MIN)) begin
            nBit = 6'(`DSL_N_MIN);
        end else if (ones > 6'(`DSL_N_MAX)) begin
            nBit = 6'(`DSL_N_MAX);
        end else begin
            nBit = ones;
        end
    end
    assign thr = {`DSL_PW{1'b1}} << nBit;
    assign ovf = !alu.res[`DSL_PW-1] && |(alu.res & thr);
    assign unf = alu.res[`DSL_PW-1] && !(&(alu.res | ~thr));

    // ----------------------------------------------------------------
    // Output stage: result, flags and cascades register together
    // ----------------------------------------------------------------
    logic [FW-1:0] outD;
    logic [FW-1:0] outQ;
    logic autoClr;
    assign outD = {mQ[`DSL_MW-1], alu.cascOut, unf, ovf, patInvHit, patHit,
                   alu.cout[1:0], alu.res};
    // A match seen in the output stage clears it at the next edge
    assign autoClr = AUTORESET && outQ[`DSL_PW+2];
    dsl_stage #(.W(FW), .PRESENT(PREG)) uP (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
        .srst(rstOf(outputRst, gRst) | autoClr), .ce(ceOf(outputEnable, gEn)),
        .d(outD), .q(outQ));

    // Upper carry bits ride a small side stage to keep the bundle lean
    logic [1:0] coutHiQ;
    dsl_stage #(.W(2), .PRESENT(PREG)) uCoHi (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
        .srst(rstOf(outputRst, gRst) | autoClr), .ce(ceOf(outputEnable, gEn)),
        .d(alu.cout[3:2]), .q(coutHiQ));

    assign p = outQ[`DSL_PW-1:0];
    assign pCascOut = outQ[`DSL_PW-1:0];
    assign carryOut = {coutHiQ, outQ[`DSL_PW+1:`DSL_PW]};
    assign patternMatch = outQ[`DSL_PW+2];
    assign patternInvMatch = outQ[`DSL_PW+3];
    assign overflow = outQ[`DSL_PW+4];
    assign underflow = outQ[`DSL_PW+5];
    assign carryCascOut = outQ[`DSL_PW+6];
    assign multSignCascOut = outQ[`DSL_PW+7];
endmodule

// [dsl_slice_sva.sv]
// Port assertions of the slice top, default build.
// Assumes one adder unit and every stage one deep.
`timescale 1ns/10ps
module dsl_slice_sva (
    // Clock, stage controls and second operand with its cascade tap
    input wire logic clk, rst_n, clkEn, outputRst, outputEnable,
    input wire logic firstOperandRst, firstOperandStage2Enable,
    input wire logic secondOperandRst, secondOperandStage2Enable,
    input wire logic [17:0] b, bCascOut,
    // Data and flags
    input wire logic [29:0] a, aCascOut,
    input wire logic [47:0] p, pCascOut,
    input wire logic [3:0] carryOut,
    input wire logic patternMatch, overflow, underflow
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic upd;
    assign upd = clkEn && outputEnable && !outputRst;
    a_out_rst: assert property (clkEn && outputRst |=> p == '0)
        else $error("p not cleared");
    a_out_hold: assert property (clkEn && !outputRst && !outputEnable |=> $stable(p))
        else $error("p moved");
    a_casc_same: assert property (!clkEn |=> $stable(p) && pCascOut == p)
        else $error("cascade differs");
    a_carry_unused: assert property (carryOut[3:1] == 3'h0)
        else $error("carry bits set");
    a_pat_flag: assert property (upd |=> patternMatch == (p[7:0] == 8'h00))
        else $error("pattern flag");
    a_ovf_flag: assert property (upd |=> overflow == (!p[47] && |p[46:40]))
        else $error("overflow flag");
    a_udf_flag: assert property (upd |=> underflow == (p[47] && !(&p[46:40])))
        else $error("underflow flag");
    a_operand_tap: assert property (
        clkEn && firstOperandStage2Enable && !firstOperandRst |=> aCascOut == $past(a))
        else $error("operand tap");
    a_second_tap: assert property (
        clkEn && secondOperandStage2Enable && !secondOperandRst |=> bCascOut == $past(b))
        else $error("second operand tap");
    c_match: cover property (upd ##1 patternMatch);
    c_ovf: cover property (upd ##1 overflow);
    c_rst: cover property (clkEn && outputRst);
endmodule
bind dsl_slice dsl_slice_sva i_sva (.*);

// [dsl_nbr_model.sv]
// Neighbour slice feeding the cascade inputs.
// Assumes the clock and reset of the block.
`timescale 1ns/10ps
module dsl_nbr_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Cascade links toward the block
    output logic [97:0] casc
);
    logic [97:0] st_r;
    logic [97:0] st_nxt;
    // A busy neighbour never holds still, so stale values cannot pass
    always_comb st_nxt = {st_r[96:0], st_r[97] ^ st_r[90]};
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) st_r <= '1;
        else st_r <= st_nxt;
    assign casc = st_r;
endmodule

// [dsl_slice_tb_top.sv]
// Self-checking bench of the slice top, default build.
// Assumes the package, checker and neighbour model compile first.
`timescale 1ns/10ps
module dsl_slice_tb_top;
    typedef struct {int due; logic [48:0] v;} dsl_note_s;
    dsl_note_s q[$];
    int cyc = 0, seed = 39, mismatches = 0, nChecks = 0;
    logic clk = 0, rst_n = 0, clkEn = 1;
    logic [29:0] a = 0, aCascOut;
    logic [17:0] b = 0, bCascOut;
    logic [47:0] c = 0, p, pCascOut;
    logic [24:0] d = 0;
    logic [19:0] ctrlWord = 0, sep = 0;
    logic [9:0] rs = 0;
    logic [12:0] en = 0;
    logic [97:0] nb;
    logic [3:0] carryOut;
    logic patternMatch, patternInvMatch, overflow, underflow, carryCascOut, multSignCascOut;
    initial forever #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    dsl_nbr_model i_nbr (.clk(clk), .rst_n(rst_n), .casc(nb));
    dsl_slice i_dut (.*, .opSel(sep[6:0]), .aluFn(sep[10:7]), .carryIn(sep[11]),
        .carrySel(sep[14:12]), .inMode(sep[19:15]), .globalRst(1'b0), .globalEn(1'b1),
        .firstOperandRst(rs[0]), .secondOperandRst(rs[1]), .thirdOperandRst(rs[2]),
        .multRst(rs[3]), .outputRst(rs[4]), .carryInRst(rs[5]), .aluFnRst(rs[6]),
        .ctrlRst(rs[7]), .preAddRst(rs[8]), .inModeRst(rs[9]),
        .firstOperandStage1Enable(en[0]), .firstOperandStage2Enable(en[1]),
        .secondOperandStage1Enable(en[2]), .secondOperandStage2Enable(en[3]),
        .thirdOperandEnable(en[4]), .multEnable(en[5]), .outputEnable(en[6]),
        .carryInEnable(en[7]), .aluFnEnable(en[8]), .ctrlEnable(en[9]),
        .preAddInEnable(en[10]), .preAddOutEnable(en[11]), .inModeEnable(en[12]),
        .aCascIn(nb[29:0]), .bCascIn(nb[47:30]), .pCascIn(nb[95:48]),
        .carryCascIn(nb[96]), .multSignCascIn(nb[97]), .carryCascOut(carryCascOut),
        .multSignCascOut(multSignCascOut));
    task automatic chk(input logic [47:0] s, input logic [47:0] e);
        nChecks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, s, e);
        end
    endtask
    task automatic conclude();
        if (mismatches == 0 && nChecks > 0 && q.size() == 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // The product lags C by one stage, so C of a cycle pairs with A, B of the one before
    task automatic stream(input logic ci);
        logic [47:0] m0;
        logic [47:0] m1;
        m1 = 0;
        ctrlWord = {8'h00, ci, 4'h0, 7'h31};
        rs = 0;
        en = '1;
        clkEn = 1;
        for (int i = 0; i < 152; i++) begin
            a = 30'($random(seed) & 32'hFFF);
            b = 18'($random(seed) & 32'hFFF);
            m0 = a * b;
            c = 48'({$random(seed), $random(seed)});
            if (i % 3 < 2) c[7:0] = (i % 3 == 0 ? 8'h00 : 8'hFF) - m1[7:0] - 8'(ci);
            if (i > 1 && i < 150) q.push_back('{cyc + 2, 49'({1'b0, c} + m1 + ci)});
            m1 = m0;
            @(posedge clk);
            #1;
        end
    endtask
    task automatic shake();
        for (int i = 0; i < 200; i++) begin
            {a, b} = 48'({$random(seed), $random(seed)});
            c = 48'({$random(seed), $random(seed)});
            {d, ctrlWord} = 45'({$random(seed), $random(seed)});
            sep = 20'($random(seed));
            rs = 10'($random(seed) & $random(seed) & $random(seed));
            en = 13'(~($random(seed) & $random(seed)));
            clkEn = 3'($random(seed)) != 3'h0;
            @(posedge clk);
            #1;
        end
    endtask
    always @(posedge clk) begin
        #2;
        if (q.size() > 0 && q[0].due == cyc) begin
            chk(p, q[0].v[47:0]);
            chk(carryOut, {3'h0, q[0].v[48]});
            chk(patternMatch, q[0].v[7:0] == 8'h00);
            chk(patternInvMatch, q[0].v[7:0] == 8'hFF);
            chk(overflow, !q[0].v[47] && |q[0].v[46:40]);
            chk(underflow, q[0].v[47] && !(&q[0].v[46:40]));
            chk(carryCascOut, q[0].v[48]);
            chk(multSignCascOut, 1'b0);
            void'(q.pop_front());
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1;
        stream(1'b0);
        shake();
        rst_n = 0;
        @(posedge clk);
        #1;
        rst_n = 1;
        stream(1'b1);
        shake();
        conclude();
    end
    initial begin
        #(2000 * 100);
        mismatches++;
        conclude();
    end
endmodule
